// ===== rtl/rpm_regs.vh
// Register offsets, field positions and reset values of the range/power block.
`ifndef RPM_REGS_VH
`define RPM_REGS_VH
`define RPM_ADDR_CFG_ONE 8'h15
`define RPM_ADDR_CFG_TWO 8'h16
`define RPM_ADDR_RATE 8'h17
`define RPM_ADDR_IDLE_LSB 8'h18
`define RPM_ADDR_IDLE_MSB 8'h19
`define RPM_CFG_ONE_RESET 8'h02
`define RPM_CFG_TWO_RESET 8'h00
`define RPM_RATE_RESET 8'h00
`define RPM_IDLE_RESET 8'h00
`define RPM_RANGE_RESET 2'h1
`define RPM_BIT_ACTIVE 0
`define RPM_RANGE_LO 1
`define RPM_RANGE_HI 2
`define RPM_BIT_PIN_CTRL 3
`define RPM_WAKE_POWER_MODE_LO 6
`define RPM_WAKE_POWER_MODE_HI 7
`define RPM_PM_LOW_POWER 2'h0
`define RPM_PM_HIGH_PERF 2'h1
`define RPM_SENS_2G 11'h400
`define RPM_SENS_4G 11'h200
`define RPM_SENS_8G 11'h100
`define RPM_SENS_16G 11'h080
`endif

// ===== rtl/rpm_range_decode.v
// Decode of the range code into full scale and sensitivity.
`timescale 1ns/1ps
`default_nettype none
module rpm_range_decode (
  // Range code in.
  input wire [1:0] range_select_in,
  // Decoded full scale in g and counts per g.
  output reg [4:0] full_scale_g_out,
  output reg [10:0] counts_per_g_out
);
`include "rpm_regs.vh"

  // Pure table; each range doubles full scale and halves sensitivity.
  always @* begin
    case (range_select_in)
      2'h0: begin
        full_scale_g_out = 5'h02;
        counts_per_g_out = `RPM_SENS_2G;
      end
      2'h1: begin
        full_scale_g_out = 5'h04;
        counts_per_g_out = `RPM_SENS_4G;
      end
      2'h2: begin
        full_scale_g_out = 5'h08;
        counts_per_g_out = `RPM_SENS_8G;
      end
      default: begin
        full_scale_g_out = 5'h10;
        counts_per_g_out = `RPM_SENS_16G;
      end
    endcase
  end
endmodule
`default_nettype wire

// ===== rtl/rpm_config.v
// Range, active/standby and wake power mode configuration registers.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - The range field picks 2, 4, 8 or 16 g at 1024, 512, 256, 128 counts.
// - After reset the range field holds code 01 for the 4 g range.
// - Active bit clear means standby, set means active measurement.
// - Power-on or soft reset leaves the device in standby.
// - With pin mode control on, the second interrupt pin sets the mode.
// - Wake power mode 00 is low power with rate bits 7:4 as rate code.
// - Wake power mode 01 is high performance with the same rate code.
// - Wake power mode 1x reads the nibble as decimation plus idle time.
// - The second config register resets to zero and is fully writable.
module rpm_config (
  // Clock and synchronous reset.
  input wire ref_clk_in,
  input wire rst_in,
  // Soft reset request, one cycle pulse.
  input wire soft_reset_in,
  // Register port from the serial interface block.
  input wire [7:0] reg_addr_in,
  input wire reg_write_in,
  input wire [7:0] reg_wdata_in,
  output reg [7:0] reg_rdata_out,
  // Second interrupt pin level.
  input wire second_interrupt_pin_in,
  // Measurement control outputs.
  output reg active_out,
  output reg [1:0] range_select_out,
  output reg [4:0] full_scale_g_out,
  output reg [10:0] counts_per_g_out,
  output reg low_power_mode_out,
  output reg high_performance_mode_out,
  output reg flexible_performance_mode_out,
  output reg [3:0] wake_rate_code_out,
  output reg [3:0] wake_decimation_code_out,
  output reg [11:0] wake_idle_time_out
);
`include "rpm_regs.vh"

  // Register state.
  reg [7:0] cfg_one_reg;
  reg [7:0] cfg_one_next;
  reg [7:0] cfg_two_reg;
  reg [7:0] rate_reg;
  reg [7:0] idle_lsb_reg;
  reg [7:0] idle_msb_reg;
  wire pin_ctrl;
  wire eff_active;
  wire [1:0] wake_power_mode;
  wire [4:0] fs_dec;
  wire [10:0] cpg_dec;
  // Shared decode results.
  wire reg_clear;
  wire wr_cfg_one;
  wire wr_cfg_two;
  wire wr_rate;
  wire wr_idle_lsb;
  wire wr_idle_msb;
  wire [2:0] pm_onehot;
  wire [3:0] rate_nibble;

  // True when the register port points at the given offset. The write
  // strobes all share this compare, so a change of offset is made in one
  // place only.
  function addr_hit;
    input [7:0] addr;
    input [7:0] target;
    begin
      addr_hit = (addr == target);
    end
  endfunction

  // One-hot of the wake power mode, ordered flexible, high performance,
  // low power. Codes 10 and 11 both mean flexible, so the upper bit alone
  // decides it and the lower bit is ignored there.
  function [2:0] pm_decode;
    input [1:0] pm;
    begin
      case (pm)
        `RPM_PM_LOW_POWER: begin
          pm_decode = 3'h1;
        end
        `RPM_PM_HIGH_PERF: begin
          pm_decode = 3'h2;
        end
        default: begin
          pm_decode = 3'h4;
        end
      endcase
    end
  endfunction

  // Soft reset clears the same registers as the reset pin. It does not
  // touch the output flops directly; they follow one edge later, which
  // keeps a single path from the registers into the measurement control.
  assign reg_clear = rst_in || soft_reset_in;

  // One write strobe per register. An unmapped offset strobes none, so a
  // stray write is dropped without side effects.
  assign wr_cfg_one = reg_write_in &&
                      addr_hit(reg_addr_in, `RPM_ADDR_CFG_ONE);
  assign wr_cfg_two = reg_write_in &&
                      addr_hit(reg_addr_in, `RPM_ADDR_CFG_TWO);
  assign wr_rate = reg_write_in &&
                   addr_hit(reg_addr_in, `RPM_ADDR_RATE);
  assign wr_idle_lsb = reg_write_in &&
                       addr_hit(reg_addr_in, `RPM_ADDR_IDLE_LSB);
  assign wr_idle_msb = reg_write_in &&
                       addr_hit(reg_addr_in, `RPM_ADDR_IDLE_MSB);

  // Wake mode decode and the rate nibble that the mode steers.
  // The nibble has one meaning per mode; the steering below decides which
  // output carries it, so consumers never have to look at the mode.
  assign pm_onehot = pm_decode(wake_power_mode);
  assign rate_nibble = rate_reg[7:4];

  // Pin control enable as stored in the first config register.
  assign pin_ctrl = cfg_one_reg[`RPM_BIT_PIN_CTRL];
  // Under pin control the pin level alone decides the mode.
  assign eff_active = pin_ctrl ? second_interrupt_pin_in :
                      cfg_one_reg[`RPM_BIT_ACTIVE];
  assign wake_power_mode = cfg_two_reg[`RPM_WAKE_POWER_MODE_HI:`RPM_WAKE_POWER_MODE_LO];

  // Next value of the first config register; the active bit is protected under pin control.
  always @* begin
    cfg_one_next = cfg_one_reg;
    if (wr_cfg_one) begin
      cfg_one_next = reg_wdata_in;
      // Pin control ignores host active writes; the order rules for host
      // are not enforced, so a bad sequence simply takes the written value.
      if (pin_ctrl) begin
        cfg_one_next[`RPM_BIT_ACTIVE] = cfg_one_reg[`RPM_BIT_ACTIVE];
      end
    end
  end

  // Registers; soft reset returns every field to its default.
  always @(posedge ref_clk_in) begin
    if (reg_clear) begin
      cfg_one_reg <= `RPM_CFG_ONE_RESET;
      cfg_two_reg <= `RPM_CFG_TWO_RESET;
      rate_reg <= `RPM_RATE_RESET;
      idle_lsb_reg <= `RPM_IDLE_RESET;
      idle_msb_reg <= `RPM_IDLE_RESET;
    end else begin
      cfg_one_reg <= cfg_one_next;
      // The other registers take the whole byte, except the idle MSB,
      // whose upper nibble is not implemented and reads back as zero.
      if (wr_cfg_two) begin
        cfg_two_reg <= reg_wdata_in;
      end
      if (wr_rate) begin
        rate_reg <= reg_wdata_in;
      end
      if (wr_idle_lsb) begin
        idle_lsb_reg <= reg_wdata_in;
      end
      if (wr_idle_msb) begin
        idle_msb_reg <= {4'h0, reg_wdata_in[3:0]};
      end
    end
  end

  // Read path; the active bit shows the mode actually in force.
  // Under pin control the host thus reads the pin-selected mode, not the
  // stored bit, which stays frozen until pin control is switched off.
  always @* begin
    case (reg_addr_in)
      `RPM_ADDR_CFG_ONE: reg_rdata_out = {cfg_one_reg[7:1], eff_active};
      `RPM_ADDR_CFG_TWO: reg_rdata_out = cfg_two_reg;
      `RPM_ADDR_RATE: reg_rdata_out = rate_reg;
      `RPM_ADDR_IDLE_LSB: reg_rdata_out = idle_lsb_reg;
      `RPM_ADDR_IDLE_MSB: reg_rdata_out = idle_msb_reg;
      default: reg_rdata_out = 8'h00;
    endcase
  end

  rpm_range_decode u_range (
    .range_select_in(cfg_one_reg[`RPM_RANGE_HI:`RPM_RANGE_LO]),
    .full_scale_g_out(fs_dec),
    .counts_per_g_out(cpg_dec)
  );

  // Registered control outputs; the rate nibble is steered by power mode.
  // They trail the registers by one edge, trading a cycle of latency for
  // glitch-free controls into the measurement chain.
  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      active_out <= 1'b0;
      range_select_out <= `RPM_RANGE_RESET;
      full_scale_g_out <= 5'h04;
      counts_per_g_out <= `RPM_SENS_4G;
      low_power_mode_out <= 1'b1;
      high_performance_mode_out <= 1'b0;
      flexible_performance_mode_out <= 1'b0;
      wake_rate_code_out <= 4'h0;
      wake_decimation_code_out <= 4'h0;
      wake_idle_time_out <= 12'h000;
    end else begin
      active_out <= eff_active;
      range_select_out <= cfg_one_reg[`RPM_RANGE_HI:`RPM_RANGE_LO];
      full_scale_g_out <= fs_dec;
      counts_per_g_out <= cpg_dec;
      low_power_mode_out <= pm_onehot[0];
      high_performance_mode_out <= pm_onehot[1];
      flexible_performance_mode_out <= pm_onehot[2];
      // In flexible mode the rate code is held at zero, so a consumer
      // cannot mistake a decimation factor for a rate code.
      if (pm_onehot[2]) begin
        wake_rate_code_out <= 4'h0;
        wake_decimation_code_out <= rate_nibble;
        wake_idle_time_out <= {idle_msb_reg[3:0], idle_lsb_reg};
      end else begin
        wake_rate_code_out <= rate_nibble;
        wake_decimation_code_out <= 4'h0;
        wake_idle_time_out <= 12'h000;
      end
    end
  end
endmodule
`default_nettype wire

// ===== verif/rpm_checker.sv
// Assertion checker for the range and power mode block.
`timescale 1ns/1ps
`default_nettype none
module rpm_checker (
  // Watched ports.
  input wire ref_clk_in, rst_in, soft_reset_in, reg_write_in,
  input wire [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out,
  input wire second_interrupt_pin_in, active_out,
  input wire [1:0] range_select_out,
  input wire [10:0] counts_per_g_out,
  input wire high_performance_mode_out, flexible_performance_mode_out,
  input wire [3:0] wake_rate_code_out, wake_decimation_code_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  // Pin control shows on bit 3 whenever the first register is addressed.
  wire at15 = reg_addr_in == 8'h15;
  wire pinc = at15 && reg_rdata_out[3];
  wire p = second_interrupt_pin_in;
  chk_range_map: assert property (
    counts_per_g_out == 11'h400 >> range_select_out) else $error("range");
  chk_reset_range: assert property (
    $past(rst_in) |-> range_select_out == 2'h1) else $error("reset");
  chk_soft_standby: assert property (
    $past(soft_reset_in) |=> !active_out) else $error("soft");
  chk_active_write: assert property (
    reg_write_in && at15 && !reg_rdata_out[3] && !reg_wdata_in[3] &&
    !soft_reset_in |=> ##1 active_out == $past(reg_wdata_in[0], 2))
    else $error("active");
  chk_pin_read: assert property (
    pinc |-> reg_rdata_out[0] == p) else $error("pin read");
  chk_pin_mode: assert property (
    pinc && $stable(p) ##1 pinc && $stable(p) |=> active_out == $past(p))
    else $error("pin mode");
  chk_wake_mode: assert property (
    reg_write_in && reg_addr_in == 8'h16 && !soft_reset_in |=> ##1
    flexible_performance_mode_out == $past(reg_wdata_in[7], 2) &&
    high_performance_mode_out == ($past(reg_wdata_in[7:6], 2) == 2'h1))
    else $error("mode");
  chk_rate_route: assert property (
    reg_addr_in == 8'h17 |=> $past(reg_rdata_out[7:4]) ==
    (flexible_performance_mode_out ? wake_decimation_code_out :
    wake_rate_code_out)) else $error("rate");
endmodule
bind rpm_config rpm_checker u_chk (.ref_clk_in, .rst_in, .soft_reset_in,
  .reg_write_in, .reg_addr_in, .reg_wdata_in, .reg_rdata_out,
  .second_interrupt_pin_in, .active_out, .range_select_out,
  .counts_per_g_out, .high_performance_mode_out,
  .flexible_performance_mode_out, .wake_rate_code_out,
  .wake_decimation_code_out);
`default_nettype wire

// ===== verif/rpm_host.sv
// Host controller model driving the register port.
`timescale 1ns/1ps
`default_nettype none
module rpm_host (
  // Clock and read data.
  input wire ref_clk_in,
  input wire [7:0] rdata_in,
  // Register requests.
  output logic [7:0] addr_out = 8'h00,
  output logic write_out = 1'b0,
  output logic [7:0] wdata_out = 8'h00
);
  // One-cycle strobe; data is scrambled after, so stale values never pass.
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk_in);
    addr_out = a;
    wdata_out = d;
    write_out = 1'b1;
    @(negedge ref_clk_in);
    write_out = 1'b0;
    wdata_out = ~d;
  endtask
  // Read data is combinational; take it at the rising edge, then return
  // off the edge so the caller looks at settled outputs.
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk_in);
    addr_out = a;
    @(posedge ref_clk_in);
    d = rdata_in;
    @(negedge ref_clk_in);
  endtask
endmodule
`default_nettype wire

// ===== verif/tb_top.sv
// Self-checking bench for the range and power mode block.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic soft_reset_in = 1'b0;
  logic second_interrupt_pin_in = 1'b0;
  logic reg_write_in, active_out, low_power_mode_out;
  logic high_performance_mode_out, flexible_performance_mode_out;
  logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, r;
  logic [1:0] range_select_out;
  logic [4:0] full_scale_g_out;
  logic [10:0] counts_per_g_out;
  logic [3:0] wake_rate_code_out, wake_decimation_code_out;
  logic [11:0] wake_idle_time_out;
  int miscompares = 0;
  int num_checks = 0;
  int i;
  // Clock at 50 MHz.
  always #10 ref_clk_in = ~ref_clk_in;
  rpm_config dut (.ref_clk_in, .rst_in, .soft_reset_in, .reg_addr_in,
    .reg_write_in, .reg_wdata_in, .reg_rdata_out, .second_interrupt_pin_in,
    .active_out, .range_select_out, .full_scale_g_out, .counts_per_g_out,
    .low_power_mode_out, .high_performance_mode_out,
    .flexible_performance_mode_out, .wake_rate_code_out,
    .wake_decimation_code_out, .wake_idle_time_out);
  rpm_host host (.ref_clk_in, .rdata_in(reg_rdata_out),
    .addr_out(reg_addr_in), .write_out(reg_write_in),
    .wdata_out(reg_wdata_in));
  // Compare and count.
  task chk(input logic [23:0] got, input logic [23:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  // Verdict and end of run.
  task conclude;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Main sequence.
  initial begin
    repeat (20) @(negedge ref_clk_in);
    rst_in = 1'b0;
    host.rd(8'h15, r);
    chk({r, active_out, counts_per_g_out}, {8'h02, 12'h200});
    host.rd(8'h30, r);
    chk(r, 8'h00);
    $display("reset test done");
    for (i = 0; i < 4; i++) begin
      host.wr(8'h15, {5'h00, i[1:0], 1'b1});
      @(negedge ref_clk_in);
      chk({active_out, full_scale_g_out, counts_per_g_out},
        {1'b1, 5'h02 << i, 11'h400 >> i});
    end
    $display("range test done");
    host.wr(8'h17, 8'ha5);
    host.wr(8'h18, 8'h3c);
    host.wr(8'h19, 8'hf7);
    for (i = 0; i < 4; i++) begin
      host.wr(8'h16, {i[1:0], 6'h2a});
      host.rd(8'h16, r);
      chk(r, {i[1:0], 6'h2a});
      chk({flexible_performance_mode_out, high_performance_mode_out,
        low_power_mode_out, wake_rate_code_out, wake_decimation_code_out,
        wake_idle_time_out}, i > 1 ? {3'h4, 8'h0a, 12'h73c} :
        {1'b0, i == 1, i == 0, 8'ha0, 12'h000});
    end
    host.wr(8'h16, 8'h00);
    host.rd(8'h17, r);
    chk({r, low_power_mode_out, wake_rate_code_out},
      {8'ha5, 1'b1, 4'ha});
    host.wr(8'h30, 8'hff);
    host.rd(8'h30, r);
    chk(r, 8'h00);
    host.rd(8'h19, r);
    chk(r, 8'h07);
    $display("mode test done");
    host.wr(8'h15, 8'h00);
    host.wr(8'h15, 8'h08);
    second_interrupt_pin_in = 1'b1;
    host.rd(8'h15, r);
    chk({r, active_out}, {8'h09, 1'b1});
    second_interrupt_pin_in = 1'b0;
    host.wr(8'h15, 8'h09);
    host.rd(8'h15, r);
    chk({r, active_out}, {8'h08, 1'b0});
    host.wr(8'h15, 8'h01);
    host.rd(8'h15, r);
    chk(r, 8'h00);
    $display("pin test done");
    host.wr(8'h15, 8'h07);
    host.wr(8'h16, 8'h40);
    soft_reset_in = 1'b1;
    @(negedge ref_clk_in);
    soft_reset_in = 1'b0;
    host.rd(8'h16, r);
    chk({r, active_out, range_select_out}, {8'h00, 3'h1});
    $display("soft reset test done");
    conclude;
  end
endmodule
`default_nettype wire
